// File: verilog/psm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module psm_monitor #(
	parameter int ERR_THRESH     = psm_pkg::ERR_THRESH,
	parameter int LOCK_HOLD_BITS = psm_pkg::LOCK_HOLD_BITS,
	parameter int SETTLE_BITS    = psm_pkg::SETTLE_BITS,
	parameter int SHIFT_RANGE    = psm_pkg::SHIFT_RANGE
) (
	// Clock and reset
	input  wire logic       CLK_I,
	input  wire logic       RST_I,
	// Despread symbols from peak detection
	input  wire logic       SYM_VALID_I,
	input  wire logic       DATA_I_I,
	input  wire logic       PILOT_Q_I,
	output logic            SYM_READY_O,
	// Recovered stream
	output logic            OUT_VALID_O,
	input  wire logic       OUT_READY_I,
	output logic            OUT_I_O,
	output logic            OUT_Q_O,
	// Sampling control and status
	output logic [$clog2(SHIFT_RANGE)-1:0] SAMPLE_OFFSET_O,
	output logic            SHIFT_PULSE_O,
	output logic            LOCKED_O,
	output logic [1:0]      ROTATION_O
);
	localparam int EW = $clog2(ERR_THRESH + 1);
	localparam int HW = $clog2(LOCK_HOLD_BITS + 1);
	localparam int OW = $clog2(SHIFT_RANGE);

	psm_pkg::psm_state_e state_ff;
	psm_pkg::psm_state_e nxt_state;
	logic [2:0]    phase_ff;
	logic [EW-1:0] err_cnt_ff;
	logic [HW-1:0] good_cnt_ff;
	logic [OW-1:0] offset_ff;
	logic [1:0]    rot_ff;
	logic          locked_ff;
	logic          shift_ff;
	logic          oi_ff;
	logic          oq_ff;
	logic          ov_ff;

	wire fifo_in_ready;
	wire take;
	wire ref_bit;
	wire rot_i;
	wire rot_q;
	wire pilot_err;
	wire thresh_hit;
	wire hold_done;
	wire settle_done;
	wire in_locked;
	wire in_shift;
	wire in_confirm;
	wire wrap_step;
	wire nxt_locked;
	wire [1:0] nxt_rot;
	wire [OW-1:0] nxt_offset;
	wire [EW-1:0] nxt_err_cnt;

	// Rotation: bit1 swaps I/Q, bit0 inverts both
	function automatic logic [1:0] psm_derot(input logic [1:0] rot, input logic di, input logic dq);
		logic a;
		logic b;
		a = rot[1] ? dq : di;
		b = rot[1] ? di : dq;
		psm_derot = {a ^ rot[0], b ^ rot[0]};
	endfunction

	// Stall the upstream while the output buffer is full
	assign SYM_READY_O = fifo_in_ready;
	assign take        = SYM_VALID_I & fifo_in_ready;
	assign ref_bit     = psm_pkg::PILOT_PATTERN[phase_ff];
	assign {rot_i, rot_q} = psm_derot(rot_ff, DATA_I_I, PILOT_Q_I);
	assign pilot_err   = take & (rot_q != ref_bit);
	assign thresh_hit  = (err_cnt_ff >= EW'(ERR_THRESH));
	assign hold_done   = (good_cnt_ff >= HW'(LOCK_HOLD_BITS));
	assign settle_done = (good_cnt_ff >= HW'(SETTLE_BITS));
	// State decodes shared by the registers below
	assign in_locked   = (state_ff == psm_pkg::PSM_LOCKED);
	assign in_shift    = (state_ff == psm_pkg::PSM_SHIFT);
	assign in_confirm  = (state_ff == psm_pkg::PSM_CONFIRM);

	// Cycle through the four rotations first, then move the sampling point
	assign nxt_rot     = in_shift ? rot_ff + 2'h1 : rot_ff;
	assign wrap_step   = in_shift & (rot_ff == 2'h3);
	assign nxt_offset  = !wrap_step ? offset_ff :
		(offset_ff == OW'(SHIFT_RANGE-1)) ? '0 : offset_ff + OW'(1);

	// Symbols taken during a shift belong to the old alignment, so they are not counted
	assign nxt_err_cnt = in_shift ? '0 :
		in_locked ? (pilot_err ? EW'(1) : '0) :
		(pilot_err && !thresh_hit) ? err_cnt_ff + EW'(1) : err_cnt_ff;

	// Any pilot error drops the lock, the one assumed out of reset as well
	assign nxt_locked  = pilot_err ? 1'b0 :
		(in_confirm && hold_done) ? 1'b1 : locked_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			psm_pkg::PSM_LOCKED: begin
				if (pilot_err) begin
					nxt_state = psm_pkg::PSM_COUNT;
				end
			end
			psm_pkg::PSM_COUNT: begin
				if (thresh_hit) begin
					nxt_state = psm_pkg::PSM_SHIFT;
				end else if (settle_done) begin
					nxt_state = psm_pkg::PSM_CONFIRM;
				end
			end
			psm_pkg::PSM_SHIFT: begin
				nxt_state = psm_pkg::PSM_COUNT;
			end
			psm_pkg::PSM_CONFIRM: begin
				if (pilot_err) begin
					nxt_state = psm_pkg::PSM_COUNT;
				end else if (hold_done) begin
					nxt_state = psm_pkg::PSM_LOCKED;
				end
			end
			default: begin
				nxt_state = psm_pkg::PSM_COUNT;
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_ff <= psm_pkg::PSM_COUNT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Local pilot phase advances on every accepted symbol
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			phase_ff <= 3'h0;
		end else if (take) begin
			phase_ff <= phase_ff + 3'h1;
		end
	end

	// Error counter cleared after each shift and on relock
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			err_cnt_ff <= '0;
		end else begin
			err_cnt_ff <= nxt_err_cnt;
		end
	end

	// Run of error-free pilot bits
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			good_cnt_ff <= '0;
		end else if (pilot_err || state_ff == psm_pkg::PSM_SHIFT) begin
			good_cnt_ff <= '0;
		end else if (take && !hold_done) begin
			good_cnt_ff <= good_cnt_ff + HW'(1);
		end
	end

	// Sampling instant and rotation only move in the shift state
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rot_ff <= 2'h0;
		end else begin
			rot_ff <= nxt_rot;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			offset_ff <= '0;
		end else begin
			offset_ff <= nxt_offset;
		end
	end

	// Pulse follows the offset step by the same edge
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			shift_ff <= 1'b0;
		end else begin
			shift_ff <= wrap_step;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			locked_ff <= 1'b1;
		end else begin
			locked_ff <= nxt_locked;
		end
	end

	psm_fifo #(
		.WIDTH (2),
		.DEPTH (psm_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (SYM_VALID_I),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({rot_i, rot_q}),
		.out_valid_o (OUT_VALID_O),
		.out_ready_i (OUT_READY_I),
		.out_data_o  ({OUT_I_O, OUT_Q_O})
	);

	assign SAMPLE_OFFSET_O = offset_ff;
	assign SHIFT_PULSE_O   = shift_ff;
	assign LOCKED_O        = locked_ff;
	assign ROTATION_O      = rot_ff;
endmodule
`default_nettype wire

// File: verilog/psm_pkg.sv
// Operation
// - Compare each despread pilot bit with an 8-bit repeating local pattern; count mismatches.
// - Error count reaching threshold marks the signal misaligned and starts sampling adjustment.
// - While misaligned, keep shifting the input sampling instant until pilot shows no errors.
// - Once locked, the sampling instant stays fixed while the pilot is error free.
// - Pilot errors after lock restart counting and sampling-shift acquisition.
// - While pilot matches, lock output high and recovered I/Q equal transmitted data.
// - After losing lock, reassert lock only after a configurable error-free duration.
// - Compensate I/Q swap and inversion caused by phase rotation using the known pilot.
package psm_pkg;
	localparam int          PILOT_LEN      = 8;
	localparam logic [7:0]  PILOT_PATTERN  = 8'hB4;
	localparam int          ERR_THRESH     = 4;
	localparam int          LOCK_HOLD_BITS = 16;
	localparam int          SETTLE_BITS    = 8;
	localparam int          SHIFT_RANGE    = 4;
	localparam int          FIFO_DEPTH     = 16;

	typedef enum logic [1:0] {
		PSM_LOCKED  = 2'b10,
		PSM_COUNT   = 2'b01,
		PSM_SHIFT   = 2'b00,
		PSM_CONFIRM = 2'b11
	} psm_state_e;
endpackage

// File: verilog/psm_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module psm_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	wire              do_wr;
	wire              do_rd;

	assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign do_wr       = in_valid_i & in_ready_o;
	assign do_rd       = out_valid_o & out_ready_i;
	assign out_data_o  = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule
`default_nettype wire

// File: tb/psm_chk.sv
`timescale 1ns/100ps
`default_nettype none
module psm_chk #(
	parameter int LOCK_HOLD_BITS = 16,
	parameter int SHIFT_RANGE    = 4
) (
	// Watched ports
	input wire logic       CLK_I,
	input wire logic       RST_I,
	input wire logic       SYM_VALID_I,
	input wire logic       DATA_I_I,
	input wire logic       PILOT_Q_I,
	input wire logic       SYM_READY_O,
	input wire logic       OUT_VALID_O,
	input wire logic       OUT_READY_I,
	input wire logic       OUT_I_O,
	input wire logic       OUT_Q_O,
	input wire logic [$clog2(SHIFT_RANGE)-1:0] SAMPLE_OFFSET_O,
	input wire logic       SHIFT_PULSE_O,
	input wire logic       LOCKED_O,
	input wire logic [1:0] ROTATION_O
);
	wire logic  take = SYM_VALID_I && SYM_READY_O;
	logic [5:0] occ_ff;
	logic [5:0] run_ff;
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			occ_ff <= 6'h00;
			run_ff <= 6'h00;
		end else begin
			occ_ff <= occ_ff + {5'h00, take} - {5'h00, OUT_VALID_O && OUT_READY_I};
			// May miss one symbol at the step edge, hence the slack below
			run_ff <= $changed(ROTATION_O) ? 6'h00 : run_ff + {5'h00, take && run_ff != 6'h3F};
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_wrap;
		ROTATION_O == 2'h3 ##1 ROTATION_O == 2'h0;
	endsequence
	a_fifo_ready: assert property (SYM_READY_O == (occ_ff != 6'h10)) else $error("ready wrong");
	a_fifo_valid: assert property (OUT_VALID_O == (occ_ff != 6'h00)) else $error("valid wrong");
	a_out_hold: assert property (OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable({OUT_I_O, OUT_Q_O}))
		else $error("output moved");
	a_lock_fixed: assert property (LOCKED_O |-> !SHIFT_PULSE_O && $stable(SAMPLE_OFFSET_O) && $stable(ROTATION_O))
		else $error("shift while locked");
	a_lock_fall: assert property ($fell(LOCKED_O) |-> $past(take) || $past(take, 2)) else $error("lock dropped");
	a_lock_run: assert property ($rose(LOCKED_O) |-> run_ff >= LOCK_HOLD_BITS - 1) else $error("early lock");
	a_rot_step: assert property ($changed(ROTATION_O) |-> ROTATION_O == $past(ROTATION_O) + 2'h1)
		else $error("rotation jump");
	a_offset_step: assert property ($changed(SAMPLE_OFFSET_O) |-> SAMPLE_OFFSET_O == $past(SAMPLE_OFFSET_O) + 1'b1)
		else $error("offset jump");
	a_wrap_pulse: assert property (s_wrap |-> ##[0:1] SHIFT_PULSE_O) else $error("no shift pulse");
endmodule
bind psm_monitor psm_chk #(
	.LOCK_HOLD_BITS  (LOCK_HOLD_BITS),
	.SHIFT_RANGE     (SHIFT_RANGE)
) chk_u (
	.CLK_I           (CLK_I),
	.RST_I           (RST_I),
	.SYM_VALID_I     (SYM_VALID_I),
	.DATA_I_I        (DATA_I_I),
	.PILOT_Q_I       (PILOT_Q_I),
	.SYM_READY_O     (SYM_READY_O),
	.OUT_VALID_O     (OUT_VALID_O),
	.OUT_READY_I     (OUT_READY_I),
	.OUT_I_O         (OUT_I_O),
	.OUT_Q_O         (OUT_Q_O),
	.SAMPLE_OFFSET_O (SAMPLE_OFFSET_O),
	.SHIFT_PULSE_O   (SHIFT_PULSE_O),
	.LOCKED_O        (LOCKED_O),
	.ROTATION_O      (ROTATION_O)
);
`default_nettype wire

// File: tb/psm_src.sv
`timescale 1ns/100ps
`default_nettype none
module psm_src (
	// Control
	input  wire logic       clk_i,
	input  wire logic       en_i,
	input  wire logic       garble_i,
	input  wire logic [1:0] rot_i,
	input  wire logic       ready_i,
	// Despread symbol
	output var  logic       valid_o = 1'b0,
	output var  logic       i_o     = 1'b0,
	output var  logic       q_o     = 1'b0
);
	logic [2:0] ph_ff = 3'h0;
	logic       di;
	logic       dq;
	always @(posedge clk_i) if (valid_o && ready_i) ph_ff <= ph_ff + 3'h1;
	always @(negedge clk_i) begin
		di = ph_ff[1] & ~garble_i;
		dq = psm_pkg::PILOT_PATTERN[ph_ff] & ~garble_i;
		valid_o <= en_i;
		// Idle lines toggle so a stale bit never looks valid
		i_o <= en_i ? (rot_i[1] ? dq : di) ^ rot_i[0] : ~i_o;
		q_o <= en_i ? (rot_i[1] ? di : dq) ^ rot_i[0] : ~q_o;
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       CLK_I = 1'b0;
	logic       RST_I = 1'b1;
	logic       OUT_READY_I = 1'b1;
	logic       SYM_VALID_I, DATA_I_I, PILOT_Q_I, SYM_READY_O, OUT_VALID_O, OUT_I_O, OUT_Q_O, SHIFT_PULSE_O, LOCKED_O;
	logic [1:0] SAMPLE_OFFSET_O, ROTATION_O;
	logic [1:0] rot = 2'h0;
	logic       en = 1'b0, garble = 1'b0, cmp_on = 1'b0;
	int         fails = 0, num_checks = 0, cyc = 0, n = 0;
	psm_monitor dut_u (
		.CLK_I           (CLK_I),
		.RST_I           (RST_I),
		.SYM_VALID_I     (SYM_VALID_I),
		.DATA_I_I        (DATA_I_I),
		.PILOT_Q_I       (PILOT_Q_I),
		.SYM_READY_O     (SYM_READY_O),
		.OUT_VALID_O     (OUT_VALID_O),
		.OUT_READY_I     (OUT_READY_I),
		.OUT_I_O         (OUT_I_O),
		.OUT_Q_O         (OUT_Q_O),
		.SAMPLE_OFFSET_O (SAMPLE_OFFSET_O),
		.SHIFT_PULSE_O   (SHIFT_PULSE_O),
		.LOCKED_O        (LOCKED_O),
		.ROTATION_O      (ROTATION_O)
	);
	psm_src src_u (.clk_i(CLK_I), .en_i(en), .garble_i(garble), .rot_i(rot), .ready_i(SYM_READY_O),
		.valid_o(SYM_VALID_I), .i_o(DATA_I_I), .q_o(PILOT_Q_I));
	always #25 CLK_I = ~CLK_I;
	task automatic complete_run;
		if (fails == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_lock(input logic lvl, input int lim);
		for (int k = 0; k < lim && LOCKED_O !== lvl; k++) @(negedge CLK_I);
	endtask
	always @(posedge CLK_I) begin
		cyc++;
		if (OUT_VALID_O && OUT_READY_I) begin
			if (cmp_on) check({OUT_I_O, OUT_Q_O}, {n[1], psm_pkg::PILOT_PATTERN[n[2:0]]});
			n++;
		end
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	task automatic t_clean;
		en = 1'b1;
		cmp_on = 1'b1;
		repeat (40) begin
			@(negedge CLK_I);
			check({LOCKED_O, SAMPLE_OFFSET_O, ROTATION_O}, 8'h10);
		end
	endtask
	task automatic t_rotate;
		cmp_on = 1'b0;
		rot = 2'h3;
		wait_lock(1'b0, 40);
		check(LOCKED_O, 8'h00);
		wait_lock(1'b1, 400);
		check({LOCKED_O, ROTATION_O}, 8'h07);
		repeat (2) @(negedge CLK_I);
		cmp_on = 1'b1;
	endtask
	task automatic t_shift;
		cmp_on = 1'b0;
		garble = 1'b1;
		for (int k = 0; k < 300 && SHIFT_PULSE_O !== 1'b1; k++) @(negedge CLK_I);
		check(SHIFT_PULSE_O, 8'h01);
		@(negedge CLK_I);
		check({LOCKED_O, SAMPLE_OFFSET_O}, 8'h01);
		garble = 1'b0;
		wait_lock(1'b1, 600);
		check({LOCKED_O, ROTATION_O}, 8'h07);
		repeat (2) @(negedge CLK_I);
		cmp_on = 1'b1;
	endtask
	task automatic t_fifo;
		int acc;
		int n0;
		acc = 0;
		en = 1'b0;
		repeat (8) @(negedge CLK_I);
		n0 = n;
		OUT_READY_I = 1'b0;
		en = 1'b1;
		repeat (40) @(posedge CLK_I) acc += int'(SYM_READY_O && SYM_VALID_I);
		@(negedge CLK_I);
		check({SYM_READY_O, 7'(acc)}, 8'h10);
		en = 1'b0;
		OUT_READY_I = 1'b1;
		repeat (40) @(negedge CLK_I);
		check({OUT_VALID_O, 7'(n - n0)}, 8'h10);
	endtask
	initial begin
		repeat (20) @(negedge CLK_I);
		RST_I = 1'b0;
		t_clean();
		t_rotate();
		t_shift();
		t_fifo();
		complete_run();
	end
endmodule
`default_nettype wire
